// ==== rtl/lmrg_pkg.sv ====
/*
 * Shared constants and types of the local memory region guard.
 * Assumes a 16-bit register offset inside the core's register space.
 */
package lmrg_pkg;

    localparam int          LMRG_NREG_MAX = 8;
    localparam int          LMRG_NMST     = 64;
    localparam logic [15:0] REGION_STRIDE = 16'h0010;

    // Scratchpad region register bases
    localparam logic [15:0] SCR_LO_OFS  = 16'hE000;
    localparam logic [15:0] SCR_UP_OFS  = 16'hE004;
    localparam logic [15:0] SCR_WLO_OFS = 16'hE008;
    localparam logic [15:0] SCR_WHI_OFS = 16'hE00C;
    localparam logic [15:0] SCR_RLO_OFS = 16'hE088;
    localparam logic [15:0] SCR_RHI_OFS = 16'hE08C;
    // Data memory unit region register bases
    localparam logic [15:0] DLM_LO_OFS  = 16'hE200;
    localparam logic [15:0] DLM_UP_OFS  = 16'hE204;
    localparam logic [15:0] DLM_WLO_OFS = 16'hE208;
    localparam logic [15:0] DLM_WHI_OFS = 16'hE20C;
    localparam logic [15:0] DLM_RLO_OFS = 16'hE288;
    localparam logic [15:0] DLM_RHI_OFS = 16'hE28C;
    // Special register write enable words
    localparam logic [15:0] SFR_WLO_OFS = 16'hE100;
    localparam logic [15:0] SFR_WHI_OFS = 16'hE104;

    // Values after reset
    localparam logic [31:0] RST_BOUND  = 32'h0000_0000;
    localparam logic [31:0] RST_ACCEN  = 32'h0000_0000;
    localparam logic [31:0] RST_SFR_EN = 32'hFFFF_FFFF;

    typedef enum logic [1:0] {
        TGT_DATA_SCRATCHPAD = 2'b00,
        TGT_PROGRAM_SCRATCHPAD = 2'b01,
        TGT_LOCAL_DATA_MEMORY_UNIT = 2'b10,
        TGT_NONE = 2'b11
    } lmrg_tgt_e;

    typedef enum logic [3:0] {
        FLD_LO   = 4'b0000,
        FLD_UP   = 4'b0001,
        FLD_WLO  = 4'b0010,
        FLD_WHI  = 4'b0011,
        FLD_RLO  = 4'b0100,
        FLD_RHI  = 4'b0101,
        FLD_SFRL = 4'b0110,
        FLD_SFRH = 4'b0111,
        FLD_NONE = 4'b1111
    } lmrg_fld_e;

    typedef struct packed {
        logic [31:0] lo;
        logic [31:0] up;
        logic [31:0] wlo;
        logic [31:0] whi;
        logic [31:0] rlo;
        logic [31:0] rhi;
    } lmrg_region_s;

    // Decoded register address
    typedef struct packed {
        logic      dlm;
        logic [2:0] idx;
        lmrg_fld_e fld;
    } lmrg_dec_s;

    typedef struct packed {
        lmrg_region_s [LMRG_NREG_MAX-1:0] scr;
        lmrg_region_s [LMRG_NREG_MAX-1:0] dlm;
        logic [LMRG_NMST-1:0]             sfr_en;
        logic [31:0]                      rdata;
        logic                             ack;
        logic                             err;
        logic                             grant;
        logic                             acc_err;
        logic                             viol;
    } lmrg_state_s;

endpackage

// ==== rtl/lmrg_decode.sv ====
/*
 * Register address decoder of the region guard.
 * Assumes word-aligned offsets; anything else decodes as unmapped.
 */
`timescale 1ns/1ps
`default_nettype none
module lmrg_decode
    import lmrg_pkg::*;
#(
    parameter int NREG = 8
) (
    input  wire logic [15:0] addr,
    output lmrg_dec_s        dec
);
    // Base plus region times stride
    function automatic logic hit(input logic [15:0] a, input logic [15:0] b,
                                 input int i);
        return a == 16'(b + 16'(i) * REGION_STRIDE);
    endfunction

    // Linear search over regions; small and fully combinational
    always_comb begin
        dec = '{dlm: 1'b0, idx: 3'd0, fld: FLD_NONE};
        if (addr == SFR_WLO_OFS) dec.fld = FLD_SFRL;
        if (addr == SFR_WHI_OFS) dec.fld = FLD_SFRH;
        for (int i = 0; i < NREG; i++) begin
            if (hit(addr, SCR_LO_OFS, i))  dec = '{1'b0, 3'(i), FLD_LO};
            if (hit(addr, SCR_UP_OFS, i))  dec = '{1'b0, 3'(i), FLD_UP};
            if (hit(addr, SCR_WLO_OFS, i)) dec = '{1'b0, 3'(i), FLD_WLO};
            if (hit(addr, SCR_WHI_OFS, i)) dec = '{1'b0, 3'(i), FLD_WHI};
            if (hit(addr, SCR_RLO_OFS, i)) dec = '{1'b0, 3'(i), FLD_RLO};
            if (hit(addr, SCR_RHI_OFS, i)) dec = '{1'b0, 3'(i), FLD_RHI};
            if (hit(addr, DLM_LO_OFS, i))  dec = '{1'b1, 3'(i), FLD_LO};
            if (hit(addr, DLM_UP_OFS, i))  dec = '{1'b1, 3'(i), FLD_UP};
            if (hit(addr, DLM_WLO_OFS, i)) dec = '{1'b1, 3'(i), FLD_WLO};
            if (hit(addr, DLM_WHI_OFS, i)) dec = '{1'b1, 3'(i), FLD_WHI};
            if (hit(addr, DLM_RLO_OFS, i)) dec = '{1'b1, 3'(i), FLD_RLO};
            if (hit(addr, DLM_RHI_OFS, i)) dec = '{1'b1, 3'(i), FLD_RHI};
        end
    end
endmodule
`default_nettype wire

// ==== rtl/lmrg_check.sv ====
/*
 * Region checker: does any enabled region admit this access.
 * Assumes master tags are 0 to 63 and bounds are byte addresses.
 */
`timescale 1ns/1ps
`default_nettype none
module lmrg_check
    import lmrg_pkg::*;
#(
    parameter int NREG = 8
) (
    input  wire lmrg_region_s [LMRG_NREG_MAX-1:0] rgn,
    input  wire logic [31:0]                      addr,
    input  wire logic [5:0]                       master,
    input  wire logic                             wr,
    output logic                                  ok
);
    // A region admits when the master bit is set and lo <= addr < up
    always_comb begin
        logic [63:0] en;
        en = '0;
        ok = 1'b0;
        for (int i = 0; i < NREG; i++) begin
            en = wr ? {rgn[i].whi, rgn[i].wlo}
                    : {rgn[i].rhi, rgn[i].rlo};
            if (en[master] && rgn[i].lo <= addr && addr < rgn[i].up) begin
                ok = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/lmrg_guard.sv ====
/*
 * Local memory region guard: register file, special register write
 * protection and the access checker for scratchpads and data memory unit.
 * Assumes one request at a time on each port, inputs synchronous to
 * CORE_CLK, and that memories honour ACC_GRANT.
 */
`timescale 1ns/1ps
`default_nettype none
module lmrg_guard
    import lmrg_pkg::*;
#(
    parameter int NREG = 8
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RESETN,
    input  wire logic        CLK_EN,
    // Crossbar slave register port
    input  wire logic        REG_REQ,
    input  wire logic        REG_WR,
    input  wire logic [15:0] REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic [5:0]  REG_MASTER,
    output logic             REG_ACK,
    output logic             REG_ERR,
    output logic [31:0]      REG_RDATA,
    input  wire logic        SFR_UNLOCK,
    // Memory access check port
    input  wire logic        ACC_REQ,
    input  wire logic        ACC_WR,
    input  wire logic [1:0]  ACC_TGT,
    input  wire logic        ACC_LOCAL,
    input  wire logic        ACC_FETCH,
    input  wire logic [31:0] ACC_ADDR,
    input  wire logic [5:0]  ACC_MASTER,
    output logic             ACC_GRANT,
    output logic             ACC_ERR,
    output logic             VIOL
);
    if (NREG < 1 || NREG > LMRG_NREG_MAX) begin : g_bad_nreg
        $error("NREG must lie between 1 and 8");
    end

    lmrg_state_s q;
    lmrg_state_s d;
    lmrg_dec_s   dec;
    logic        scr_ok;
    logic        dlm_ok;
    logic        bypass;
    logic        acc_ok;
    logic        wr_allowed;

    lmrg_decode #(.NREG(NREG)) u_dec (
        .addr (REG_ADDR),
        .dec  (dec)
    );

    lmrg_check #(.NREG(NREG)) u_scr (
        .rgn    (q.scr),
        .addr   (ACC_ADDR),
        .master (ACC_MASTER),
        .wr     (ACC_WR),
        .ok     (scr_ok)
    );

    lmrg_check #(.NREG(NREG)) u_dlm (
        .rgn    (q.dlm),
        .addr   (ACC_ADDR),
        .master (ACC_MASTER),
        .wr     (ACC_WR),
        .ok     (dlm_ok)
    );

    // Read one field of a region
    function automatic logic [31:0] rd_fld(input lmrg_region_s r,
                                           input lmrg_fld_e f);
        case (f)
            FLD_LO:  return r.lo;
            FLD_UP:  return r.up;
            FLD_WLO: return r.wlo;
            FLD_WHI: return r.whi;
            FLD_RLO: return r.rlo;
            FLD_RHI: return r.rhi;
            default: return 32'h0000_0000;
        endcase
    endfunction

    // Write one field of a region
    function automatic lmrg_region_s wr_fld(input lmrg_region_s r,
                                            input lmrg_fld_e f,
                                            input logic [31:0] v);
        lmrg_region_s t;
        t = r;
        case (f)
            FLD_LO:  t.lo = v;
            FLD_UP:  t.up = v;
            FLD_WLO: t.wlo = v;
            FLD_WHI: t.whi = v;
            FLD_RLO: t.rlo = v;
            FLD_RHI: t.rhi = v;
            default: t = r;
        endcase
        return t;
    endfunction

    // Local core bypass of the scratchpad check only
    assign bypass = ACC_LOCAL &&
                    ((ACC_TGT == TGT_DATA_SCRATCHPAD && !ACC_FETCH) ||
                     (ACC_TGT == TGT_PROGRAM_SCRATCHPAD &&  ACC_FETCH));

    // Reserved target codes are refused rather than passed
    always_comb begin
        case (ACC_TGT)
            TGT_DATA_SCRATCHPAD: acc_ok = bypass || scr_ok;
            TGT_PROGRAM_SCRATCHPAD: acc_ok = bypass || scr_ok;
            TGT_LOCAL_DATA_MEMORY_UNIT: acc_ok = dlm_ok;
            default:  acc_ok = 1'b0;
        endcase
    end

    // Every crossbar write needs the master's special register bit
    assign wr_allowed = q.sfr_en[REG_MASTER];

    // Next state of registers and both answer ports
    always_comb begin
        d         = q;
        d.ack     = 1'b0;
        d.err     = 1'b0;
        d.rdata   = 32'h0000_0000;
        d.grant   = 1'b0;
        d.acc_err = 1'b0;
        d.viol    = 1'b0;
        if (REG_REQ) begin
            d.ack = 1'b1;
            if (dec.fld == FLD_NONE) begin
                d.err = 1'b1;
            end else if (!REG_WR) begin
                case (dec.fld)
                    FLD_SFRL: d.rdata = q.sfr_en[31:0];
                    FLD_SFRH: d.rdata = q.sfr_en[63:32];
                    default: begin
                        d.rdata = dec.dlm ? rd_fld(q.dlm[dec.idx], dec.fld)
                                          : rd_fld(q.scr[dec.idx], dec.fld);
                    end
                endcase
            end else if (!wr_allowed) begin
                d.err = 1'b1;
            end else begin
                case (dec.fld)
                    FLD_SFRL: begin
                        if (SFR_UNLOCK) d.sfr_en[31:0] = REG_WDATA;
                        else d.err = 1'b1;
                    end
                    FLD_SFRH: begin
                        if (SFR_UNLOCK) d.sfr_en[63:32] = REG_WDATA;
                        else d.err = 1'b1;
                    end
                    default: begin
                        if (dec.dlm)
                            d.dlm[dec.idx] = wr_fld(q.dlm[dec.idx], dec.fld,
                                                    REG_WDATA);
                        else
                            d.scr[dec.idx] = wr_fld(q.scr[dec.idx], dec.fld,
                                                    REG_WDATA);
                    end
                endcase
            end
        end
        if (ACC_REQ) begin
            d.grant   = acc_ok;
            d.acc_err = !acc_ok;
            d.viol    = !acc_ok;
        end
    end

    // All state frozen while CLK_EN is low
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < LMRG_NREG_MAX; i++) begin
                q.scr[i] <= '{RST_BOUND, RST_BOUND, RST_ACCEN, RST_ACCEN,
                              RST_ACCEN, RST_ACCEN};
                q.dlm[i] <= '{RST_BOUND, RST_BOUND, RST_ACCEN, RST_ACCEN,
                              RST_ACCEN, RST_ACCEN};
            end
            q.sfr_en  <= {RST_SFR_EN, RST_SFR_EN};
            q.rdata   <= 32'h0000_0000;
            q.ack     <= 1'b0;
            q.err     <= 1'b0;
            q.grant   <= 1'b0;
            q.acc_err <= 1'b0;
            q.viol    <= 1'b0;
        end else if (CLK_EN) begin
            q <= d;
        end
    end

    // Registered outputs
    assign REG_ACK   = q.ack;
    assign REG_ERR   = q.err;
    assign REG_RDATA = q.rdata;
    assign ACC_GRANT = q.grant;
    assign ACC_ERR   = q.acc_err;
    assign VIOL      = q.viol;

    // Checks on the answers
    AST_ACC_ONE_ANSWER: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN) (ACC_REQ && CLK_EN) |=> (ACC_GRANT != ACC_ERR))
        else $error("access not answered by exactly one of grant and error");

    AST_LOCAL_DATA_MEMORY_UNIT_LOCAL: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN)
        (ACC_REQ && CLK_EN && ACC_TGT == TGT_LOCAL_DATA_MEMORY_UNIT && !dlm_ok)
        |=> (ACC_ERR && !ACC_GRANT))
        else $error("data memory access outside regions was granted");

    AST_DATA_SCRATCHPAD_BYPASS: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN)
        (ACC_REQ && CLK_EN && ACC_TGT == TGT_DATA_SCRATCHPAD && ACC_LOCAL && !ACC_FETCH)
        |=> ACC_GRANT)
        else $error("local data access to data scratchpad refused");

    AST_PROGRAM_SCRATCHPAD_BYPASS: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN)
        (ACC_REQ && CLK_EN && ACC_TGT == TGT_PROGRAM_SCRATCHPAD && ACC_LOCAL && ACC_FETCH)
        |=> ACC_GRANT)
        else $error("local fetch from program scratchpad refused");

    AST_SCR_CHECKED: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN)
        (ACC_REQ && CLK_EN && ACC_TGT != TGT_LOCAL_DATA_MEMORY_UNIT && !bypass && !scr_ok)
        |=> ##0 (ACC_ERR && VIOL))
        else $error("scratchpad access outside regions not refused");

    AST_SFR_MASTER: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN)
        (REG_REQ && REG_WR && CLK_EN && !wr_allowed) |=> (REG_ACK && REG_ERR))
        else $error("write by untrusted master not refused");

    AST_SFR_LOCK: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN)
        (REG_REQ && REG_WR && CLK_EN && !SFR_UNLOCK &&
         (dec.fld == FLD_SFRL || dec.fld == FLD_SFRH))
        |=> (q.sfr_en == $past(q.sfr_en) && REG_ERR))
        else $error("locked special register enable word changed");

    AST_UNMAPPED: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN)
        (REG_REQ && CLK_EN && dec.fld == FLD_NONE)
        |=> (REG_ERR && REG_RDATA == 32'h0000_0000))
        else $error("unmapped register offset not refused");

    AST_VIOL_PULSE: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN) VIOL |-> (ACC_ERR && !ACC_GRANT))
        else $error("violation pulse without refused access");

    // Positive answers too, so a guard stuck at refusing is caught; also refused-write, reserved-target and idle checks
    AST_REG_ANSWER: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN) (REG_REQ && CLK_EN) |=> REG_ACK)
        else $error("register request not acknowledged next cycle");

    AST_WR_NO_CHANGE: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN)
        (REG_REQ && REG_WR && CLK_EN && !wr_allowed)
        |=> (q.scr == $past(q.scr) && q.dlm == $past(q.dlm) &&
             q.sfr_en == $past(q.sfr_en)))
        else $error("refused register write changed a register");

    AST_SCR_GRANT: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN)
        (ACC_REQ && CLK_EN && ACC_TGT inside {TGT_DATA_SCRATCHPAD, TGT_PROGRAM_SCRATCHPAD} && scr_ok)
        |=> (ACC_GRANT && !VIOL))
        else $error("enabled in-range scratchpad access refused");

    AST_LOCAL_DATA_MEMORY_UNIT_GRANT: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN)
        (ACC_REQ && CLK_EN && ACC_TGT == TGT_LOCAL_DATA_MEMORY_UNIT && dlm_ok)
        |=> (ACC_GRANT && !VIOL))
        else $error("enabled in-range data memory access refused");

    AST_RESERVED_TGT: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN)
        (ACC_REQ && CLK_EN && ACC_TGT == TGT_NONE) |=> (ACC_ERR && VIOL))
        else $error("reserved target code was not refused");

    AST_ACC_IDLE: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN)
        (!ACC_REQ && CLK_EN) |=> (!ACC_GRANT && !ACC_ERR && !VIOL))
        else $error("access answer without a request");
endmodule
`default_nettype wire

// ==== verification/lmrg_master.sv ====
/*
 * Crossbar master model: register transfers and access-check requests.
 * Assumes the guard takes a request at a rising edge and registers its
 * answer at that same edge; requests are launched from the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module lmrg_master (
    input  wire logic        CORE_CLK,
    output logic             REG_REQ,
    output logic             REG_WR,
    output logic [15:0]      REG_ADDR,
    output logic [31:0]      REG_WDATA,
    output logic [5:0]       REG_MASTER,
    input  wire logic        REG_ACK,
    input  wire logic        REG_ERR,
    input  wire logic [31:0] REG_RDATA,
    output logic             ACC_REQ,
    output logic             ACC_WR,
    output logic [1:0]       ACC_TGT,
    output logic             ACC_LOCAL,
    output logic             ACC_FETCH,
    output logic [31:0]      ACC_ADDR,
    output logic [5:0]       ACC_MASTER,
    input  wire logic        ACC_GRANT,
    input  wire logic        ACC_ERR,
    input  wire logic        VIOL
);
    // Idle at time zero
    initial begin
        {REG_REQ, REG_WR, ACC_REQ, ACC_WR, ACC_LOCAL, ACC_FETCH} = '0;
        {REG_ADDR, REG_WDATA, REG_MASTER, ACC_TGT, ACC_ADDR, ACC_MASTER} = '0;
    end

    // One register transfer; released address and write data lines show the inverse value
    // so a guard that samples them late never sees stale data
    task automatic reg_xfer(input  logic        wr,
                            input  logic [15:0] a,
                            input  logic [31:0] d,
                            input  logic [5:0]  m,
                            output logic [1:0]  ae,
                            output logic [31:0] rd);
        @(negedge CORE_CLK);
        REG_REQ    = 1'h1;
        REG_WR     = wr;
        REG_ADDR   = a;
        REG_WDATA  = d;
        REG_MASTER = m;
        @(negedge CORE_CLK);
        ae         = {REG_ACK, REG_ERR};
        rd         = REG_RDATA;
        REG_REQ    = 1'h0;
        REG_ADDR   = ~a;
        REG_WDATA  = ~d;
    endtask

    // One access check; answer is {grant, error, violation}
    task automatic acc_xfer(input  logic        w,
                            input  logic [1:0]  t,
                            input  logic        l,
                            input  logic        f,
                            input  logic [31:0] a,
                            input  logic [5:0]  m,
                            output logic [2:0]  gev);
        @(negedge CORE_CLK);
        ACC_REQ    = 1'h1;
        ACC_WR     = w;
        ACC_TGT    = t;
        ACC_LOCAL  = l;
        ACC_FETCH  = f;
        ACC_ADDR   = a;
        ACC_MASTER = m;
        @(negedge CORE_CLK);
        gev        = {ACC_GRANT, ACC_ERR, VIOL};
        ACC_REQ    = 1'h0;
        ACC_ADDR   = ~a;
    endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
/*
 * Self-checking bench of the local memory region guard.
 * Assumes lmrg_master drives both request ports from the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench
    import lmrg_pkg::*;
;
    typedef struct packed {
        logic        wr;
        logic [1:0]  tgt;
        logic        loc;
        logic        fch;
        logic [31:0] addr;
        logic [5:0]  mst;
        logic        ok;
    } lmrg_row_s;

    logic        core_clk = 1'h0;
    logic        resetn   = 1'h0;
    logic        clk_en   = 1'h1;
    logic        unlock   = 1'h0;
    logic        reg_req, reg_wr, reg_ack, reg_err, acc_req, acc_wr;
    logic        acc_local, acc_fetch, acc_grant, acc_err, viol;
    logic [1:0]  acc_tgt, ae;
    logic [2:0]  gev, exp_gev;
    logic [5:0]  reg_master, acc_master;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, acc_addr, rd;
    int          num_errors      = 0;
    int          samples_checked = 0;

    // Masters 5 and 40 own data region 3 and scratch region 2
    lmrg_row_s rows [17] = '{
        '{1'h1, 2'h2, 1'h0, 1'h0, 32'h0000_1000, 6'h05, 1'h1},
        '{1'h1, 2'h2, 1'h0, 1'h0, 32'h0000_1FFF, 6'h05, 1'h1},
        '{1'h1, 2'h2, 1'h0, 1'h0, 32'h0000_2000, 6'h05, 1'h0},
        '{1'h1, 2'h2, 1'h0, 1'h0, 32'h0000_0FFF, 6'h05, 1'h0},
        '{1'h1, 2'h2, 1'h0, 1'h0, 32'h0000_1000, 6'h06, 1'h0},
        '{1'h0, 2'h2, 1'h0, 1'h0, 32'h0000_1000, 6'h05, 1'h0},
        '{1'h0, 2'h2, 1'h0, 1'h0, 32'h0000_1800, 6'h28, 1'h1},
        '{1'h1, 2'h2, 1'h1, 1'h0, 32'h0000_0000, 6'h09, 1'h0},
        '{1'h0, 2'h0, 1'h0, 1'h0, 32'h0000_3000, 6'h05, 1'h1},
        '{1'h1, 2'h0, 1'h0, 1'h0, 32'h0000_3000, 6'h05, 1'h0},
        '{1'h1, 2'h1, 1'h0, 1'h0, 32'h0000_3FFF, 6'h28, 1'h1},
        '{1'h1, 2'h1, 1'h0, 1'h0, 32'h0000_4000, 6'h28, 1'h0},
        '{1'h1, 2'h0, 1'h1, 1'h0, 32'h0000_0000, 6'h09, 1'h1},
        '{1'h0, 2'h0, 1'h1, 1'h1, 32'h0000_0000, 6'h09, 1'h0},
        '{1'h0, 2'h1, 1'h1, 1'h1, 32'h0000_0000, 6'h09, 1'h1},
        '{1'h0, 2'h1, 1'h1, 1'h0, 32'h0000_0000, 6'h09, 1'h0},
        '{1'h0, 2'h3, 1'h0, 1'h0, 32'h0000_3000, 6'h05, 1'h0}
    };

    lmrg_guard #(.NREG(8)) i_dut (
        .CORE_CLK(core_clk), .RESETN(resetn), .CLK_EN(clk_en),
        .REG_REQ(reg_req), .REG_WR(reg_wr), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_MASTER(reg_master),
        .REG_ACK(reg_ack), .REG_ERR(reg_err), .REG_RDATA(reg_rdata),
        .SFR_UNLOCK(unlock), .ACC_REQ(acc_req), .ACC_WR(acc_wr),
        .ACC_TGT(acc_tgt), .ACC_LOCAL(acc_local), .ACC_FETCH(acc_fetch),
        .ACC_ADDR(acc_addr), .ACC_MASTER(acc_master),
        .ACC_GRANT(acc_grant), .ACC_ERR(acc_err), .VIOL(viol)
    );

    lmrg_master i_mst (
        .CORE_CLK(core_clk), .REG_REQ(reg_req), .REG_WR(reg_wr),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_MASTER(reg_master), .REG_ACK(reg_ack), .REG_ERR(reg_err),
        .REG_RDATA(reg_rdata), .ACC_REQ(acc_req), .ACC_WR(acc_wr),
        .ACC_TGT(acc_tgt), .ACC_LOCAL(acc_local), .ACC_FETCH(acc_fetch),
        .ACC_ADDR(acc_addr), .ACC_MASTER(acc_master),
        .ACC_GRANT(acc_grant), .ACC_ERR(acc_err), .VIOL(viol)
    );

    // 20 MHz core clock
    always #25 core_clk = ~core_clk;

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Register write with the expected error flag
    task automatic wr(input logic [15:0] a, input logic [31:0] d,
                      input logic [5:0] m, input logic err);
        i_mst.reg_xfer(1'h1, a, d, m, ae, rd);
        chk({30'h0, ae}, {30'h0, 1'h1, err});
    endtask

    // Register read; reads never check the master
    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
        i_mst.reg_xfer(1'h0, a, 32'h0000_0000, 6'h3F, ae, rd);
        chk({30'h0, ae}, 32'h0000_0002);
        chk(rd, exp);
    endtask

    // Watchdog: the sequence needs about a hundred cycles
    initial begin
        #(1000 * 50);
        num_errors++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        repeat (5) @(negedge core_clk);
        resetn = 1'h1;
        rdchk(DLM_LO_OFS + 16'h0070, RST_BOUND);
        rdchk(SCR_RLO_OFS + 16'h0070, RST_ACCEN);
        rdchk(SFR_WHI_OFS, RST_SFR_EN);
        // Unmapped hole between the scratch enable words
        i_mst.reg_xfer(1'h0, 16'hE080, 32'h0000_0000, 6'h00, ae, rd);
        chk({30'h0, ae}, 32'h0000_0003);
        chk(rd, 32'h0000_0000);
        // Program one data region and one scratch region
        wr(DLM_LO_OFS + 16'h0030, 32'h0000_1000, 6'h00, 1'h0);
        wr(DLM_UP_OFS + 16'h0030, 32'h0000_2000, 6'h00, 1'h0);
        wr(DLM_WLO_OFS + 16'h0030, 32'h0000_0020, 6'h00, 1'h0);
        wr(DLM_RHI_OFS + 16'h0030, 32'h0000_0100, 6'h00, 1'h0);
        wr(SCR_LO_OFS + 16'h0020, 32'h0000_3000, 6'h00, 1'h0);
        wr(SCR_UP_OFS + 16'h0020, 32'h0000_4000, 6'h00, 1'h0);
        wr(SCR_RLO_OFS + 16'h0020, 32'h0000_0020, 6'h00, 1'h0);
        wr(SCR_WHI_OFS + 16'h0020, 32'h0000_0100, 6'h00, 1'h0);
        rdchk(DLM_RHI_OFS + 16'h0030, 32'h0000_0100);
        rdchk(DLM_WLO_OFS + 16'h0030, 32'h0000_0020);
        rdchk(SCR_RLO_OFS + 16'h0020, 32'h0000_0020);
        rdchk(DLM_LO_OFS + 16'h0020, RST_BOUND);
        // Access table: bounds, enables, bypass, reserved target
        foreach (rows[k]) begin
            i_mst.acc_xfer(rows[k].wr, rows[k].tgt, rows[k].loc,
                           rows[k].fch, rows[k].addr, rows[k].mst, gev);
            exp_gev = {rows[k].ok, ~rows[k].ok, ~rows[k].ok};
            chk(32'(gev), 32'(exp_gev));
        end
        // Enable words stay locked without the unlock
        wr(SFR_WLO_OFS, 32'hFFFF_FFDF, 6'h00, 1'h1);
        rdchk(SFR_WLO_OFS, RST_SFR_EN);
        unlock = 1'h1;
        wr(SFR_WLO_OFS, 32'hFFFF_FFDF, 6'h00, 1'h0);
        wr(SFR_WHI_OFS, 32'hFFFF_FEFF, 6'h00, 1'h0);
        unlock = 1'h0;
        // Untrusted masters 5 and 40 lose register writes only
        wr(DLM_LO_OFS, 32'h0000_0040, 6'h05, 1'h1);
        wr(DLM_LO_OFS, 32'h0000_0040, 6'h28, 1'h1);
        rdchk(DLM_LO_OFS, RST_BOUND);
        wr(DLM_LO_OFS, 32'h0000_0040, 6'h06, 1'h0);
        rdchk(DLM_LO_OFS, 32'h0000_0040);
        i_mst.acc_xfer(1'h1, 2'h2, 1'h0, 1'h0, 32'h0000_1000, 6'h05, gev);
        chk({29'h0, gev}, 32'h0000_0004);
        // Frozen clock enable: nothing is taken, the last grant stands
        clk_en = 1'h0;
        i_mst.reg_xfer(1'h1, DLM_LO_OFS, 32'h0000_0080, 6'h06, ae, rd);
        chk({30'h0, ae}, 32'h0000_0000);
        i_mst.acc_xfer(1'h1, 2'h2, 1'h0, 1'h0, 32'h0000_1000, 6'h06, gev);
        chk({29'h0, gev}, 32'h0000_0004);
        clk_en = 1'h1;
        rdchk(DLM_LO_OFS, 32'h0000_0040);
        // A second reset clears regions and reopens the enable words
        resetn = 1'h0;
        @(negedge core_clk);
        resetn = 1'h1;
        rdchk(DLM_UP_OFS + 16'h0030, RST_BOUND);
        rdchk(SFR_WLO_OFS, RST_SFR_EN);
        i_mst.acc_xfer(1'h0, 2'h2, 1'h0, 1'h0, 32'h0000_1800, 6'h28, gev);
        chk({29'h0, gev}, 32'h0000_0003);
        tally_and_finish();
    end
endmodule
`default_nettype wire
